// >>> src/cad_defines.vh
`ifndef CAD_DEFINES_VH
`define CAD_DEFINES_VH

// instruction field positions
`define CAD_GRP_HI 15
`define CAD_GRP_LO 13
`define CAD_OP2_HI 12
`define CAD_OP2_LO 11
`define CAD_F4_TAG_HI 15
`define CAD_F4_TAG_LO 10
`define CAD_ALUOP_HI 9
`define CAD_ALUOP_LO 6
`define CAD_DST_HI 2
`define CAD_DST_LO 0
`define CAD_SRC_HI 5
`define CAD_SRC_LO 3
`define CAD_SEC_HI 8
`define CAD_SEC_LO 6
`define CAD_IMM5_HI 10
`define CAD_IMM5_LO 6
`define CAD_F3_DST_HI 10
`define CAD_F3_DST_LO 8
`define CAD_IMM8_HI 7
`define CAD_IMM8_LO 0
`define CAD_F2_IMMSEL 10
`define CAD_F2_SUB 9

// format identification codes
`define CAD_GRP_SHIFT 3'h0
`define CAD_GRP_IMM8 3'h1
`define CAD_OP2_ADDSUB 2'h3
`define CAD_F4_TAG 6'h10

// internal format selector
`define CAD_FMT_SHIFT 2'h0
`define CAD_FMT_ADDSUB 2'h1
`define CAD_FMT_IMM8 2'h2
`define CAD_FMT_ALU 2'h3

// shift kinds; lsl, lsr and asr are also the shift-by-immediate op codes
`define CAD_SH_LSL 2'h0
`define CAD_SH_LSR 2'h1
`define CAD_SH_ASR 2'h2
`define CAD_SH_ROR 2'h3

// byte immediate op codes
`define CAD_I8_MOV 2'h0
`define CAD_I8_CMP 2'h1
`define CAD_I8_ADD 2'h2
`define CAD_I8_SUB 2'h3

// register alu op codes
`define CAD_ALU_AND 4'h0
`define CAD_ALU_EOR 4'h1
`define CAD_ALU_LSL 4'h2
`define CAD_ALU_LSR 4'h3
`define CAD_ALU_ASR 4'h4
`define CAD_ALU_ADC 4'h5
`define CAD_ALU_SBC 4'h6
`define CAD_ALU_ROR 4'h7
`define CAD_ALU_TST 4'h8
`define CAD_ALU_NEG 4'h9
`define CAD_ALU_CMP 4'ha
`define CAD_ALU_CMN 4'hb
`define CAD_ALU_ORR 4'hc
`define CAD_ALU_MUL 4'hd
`define CAD_ALU_BIC 4'he
`define CAD_ALU_MVN 4'hf

// reset value of the flags {n,z,c,v}
`define CAD_FLAGS_RST 4'h0

// extra internal cycles beyond the base cycle
`define CAD_XTRA_REGSHIFT 3'h1
`define CAD_XTRA_MUL1 3'h1
`define CAD_XTRA_MUL2 3'h2
`define CAD_XTRA_MUL3 3'h3
`define CAD_XTRA_MUL4 3'h4

`endif

// >>> src/cad_exec.v
// How it works
// - shift op 00 left, 01 logical, 10 arithmetic
// - every covered instruction updates the flags
// - op bit add/sub, select bit register/immediate
// - subtract is source minus second operand
// - byte op 00 loads zero-extended immediate
// - byte op 01 compares, no register write
// - byte op 10 adds, 11 subtracts in place
// - and, xor, or, and-not, invert source
// - register shifts left, lsr, asr, rotate
// - add with carry
// - subtract with inverted carry borrow
// - test sets flags from and, no write
// - compare and compare-negative, no write
// - negate is zero minus source
// - multiply keeps low word, sets flags
// - cycles match the wide equivalent instruction
// - all operands come from the low group
// - low group is registers zero to seven
`timescale 1ns/1ps
`include "cad_defines.vh"

module cad_exec (
   input wire CLK_SYS,
   input wire RESET,
   input wire INSTR_VALID,
   input wire [15:0] INSTR,
   input wire [31:0] RD_DATA_A,
   input wire [31:0] RD_DATA_B,
   output reg INSTR_READY,
   output reg INSTR_ILLEGAL,
   output reg [2:0] RD_ADDR_A,
   output reg [2:0] RD_ADDR_B,
   output reg WR_EN,
   output reg [2:0] WR_ADDR,
   output reg [31:0] WR_DATA,
   output reg DONE,
   output reg FLAG_N,
   output reg FLAG_Z,
   output reg FLAG_C,
   output reg FLAG_V
);

   localparam ST_IDLE = 2'h0;
   localparam ST_EXEC = 2'h1;
   localparam ST_WAIT = 2'h2;

   reg [1:0] state;
   reg [15:0] ir;
   reg [1:0] fmt;
   reg [2:0] dest;
   reg [2:0] cnt;
   reg [31:0] res_q;
   reg wr_q;
   reg [3:0] flags_q;

   // decode of the incoming word
   wire [2:0] in_grp = INSTR[`CAD_GRP_HI:`CAD_GRP_LO];
   wire [1:0] in_op2 = INSTR[`CAD_OP2_HI:`CAD_OP2_LO];
   wire in_f4 = (INSTR[`CAD_F4_TAG_HI:`CAD_F4_TAG_LO] == `CAD_F4_TAG);
   wire in_f12 = (in_grp == `CAD_GRP_SHIFT);
   wire in_f3 = (in_grp == `CAD_GRP_IMM8);
   wire in_legal = in_f12 | in_f3 | in_f4;
   wire take = INSTR_VALID & INSTR_READY;

   // shifter: returns {carry, result}; amount zero keeps value and carry
   function [32:0] cad_shift;
      input [1:0] kind;
      input [31:0] val;
      input [7:0] amt;
      input cin;
      reg [32:0] t;
      reg [4:0] r;
      begin
         t = {cin, val};
         r = amt[4:0];
         if (amt != 8'h00) begin
            case (kind)
               `CAD_SH_LSL: begin
                  t = {1'b0, val} << amt;
               end
               `CAD_SH_LSR: begin
                  t = {val, 1'b0} >> amt;
                  t = {t[0], t[32:1]};
               end
               `CAD_SH_ASR: begin
                  t = $signed({val, 1'b0}) >>> amt;
                  t = {t[0], t[32:1]};
               end
               default: begin
                  t[31:0] = (val >> r) | (val << (6'h20 - {1'b0, r}));
                  t[32] = t[31];
               end
            endcase
         end
         cad_shift = t;
      end
   endfunction

   // adder: returns {overflow, carry, sum}
   function [33:0] cad_add;
      input [31:0] x;
      input [31:0] y;
      input cin;
      reg [32:0] s;
      begin
         s = {1'b0, x} + {1'b0, y} + {32'h0, cin};
         cad_add = {(x[31] == y[31]) && (s[31] != x[31]), s};
      end
   endfunction

   // execution datapath, operands arrive while in the exec state
   reg [31:0] a;
   reg [31:0] b;
   reg [31:0] ax;
   reg [31:0] bx;
   reg ci;
   reg use_add;
   reg [33:0] s;
   reg [32:0] t;
   reg [31:0] res;
   reg nc;
   reg nv;
   reg wr;
   reg [2:0] extra;
   reg [1:0] rk;
   always @* begin
      a = RD_DATA_A;
      b = RD_DATA_B;
      ax = 32'h0;
      bx = 32'h0;
      ci = 1'b0;
      use_add = 1'b0;
      t = 33'h0;
      res = 32'h0;
      nc = FLAG_C;
      nv = FLAG_V;
      wr = 1'b1;
      extra = 3'h0;
      rk = `CAD_SH_LSL;
      case (fmt)
         `CAD_FMT_SHIFT: begin
            // immediate of zero on lsr/asr means a shift of thirty-two
            if (ir[`CAD_IMM5_HI:`CAD_IMM5_LO] == 5'h00 && ir[`CAD_OP2_HI:`CAD_OP2_LO] != `CAD_SH_LSL)
               t = cad_shift(ir[`CAD_OP2_HI:`CAD_OP2_LO], a, 8'h20, FLAG_C);
            else
               t = cad_shift(ir[`CAD_OP2_HI:`CAD_OP2_LO], a,
                  {3'h0, ir[`CAD_IMM5_HI:`CAD_IMM5_LO]}, FLAG_C);
            res = t[31:0];
            nc = t[32];
         end
         `CAD_FMT_ADDSUB: begin
            use_add = 1'b1;
            ax = a;
            bx = ir[`CAD_F2_IMMSEL] ? {29'h0, ir[`CAD_SEC_HI:`CAD_SEC_LO]} : b;
            if (ir[`CAD_F2_SUB]) begin
               bx = ~bx;
               ci = 1'b1;
            end
         end
         `CAD_FMT_IMM8: begin
            ax = a;
            bx = {24'h0, ir[`CAD_IMM8_HI:`CAD_IMM8_LO]};
            case (ir[`CAD_OP2_HI:`CAD_OP2_LO])
               `CAD_I8_MOV: res = bx;
               `CAD_I8_CMP: begin
                  use_add = 1'b1;
                  bx = ~bx;
                  ci = 1'b1;
                  wr = 1'b0;
               end
               `CAD_I8_ADD: use_add = 1'b1;
               default: begin
                  use_add = 1'b1;
                  bx = ~bx;
                  ci = 1'b1;
               end
            endcase
         end
         default: begin
            ax = a;
            bx = b;
            case (ir[`CAD_ALUOP_HI:`CAD_ALUOP_LO])
               `CAD_ALU_AND: res = a & b;
               `CAD_ALU_EOR: res = a ^ b;
               `CAD_ALU_ORR: res = a | b;
               `CAD_ALU_BIC: res = a & ~b;
               `CAD_ALU_MVN: res = ~b;
               `CAD_ALU_TST: begin
                  res = a & b;
                  wr = 1'b0;
               end
               `CAD_ALU_LSL, `CAD_ALU_LSR, `CAD_ALU_ASR, `CAD_ALU_ROR: begin
                  // only rotate's low bits equal its shift kind (lsl two, lsr three, asr four, rotate seven), so each is mapped here
                  case (ir[`CAD_ALUOP_HI:`CAD_ALUOP_LO])
                     `CAD_ALU_LSL: rk = `CAD_SH_LSL;
                     `CAD_ALU_LSR: rk = `CAD_SH_LSR;
                     `CAD_ALU_ASR: rk = `CAD_SH_ASR;
                     default: rk = `CAD_SH_ROR;
                  endcase
                  t = cad_shift(rk, a, b[7:0], FLAG_C);
                  res = t[31:0];
                  nc = t[32];
                  extra = `CAD_XTRA_REGSHIFT;
               end
               `CAD_ALU_ADC: begin
                  use_add = 1'b1;
                  ci = FLAG_C;
               end
               `CAD_ALU_SBC: begin
                  use_add = 1'b1;
                  bx = ~b;
                  ci = FLAG_C;
               end
               `CAD_ALU_NEG: begin
                  use_add = 1'b1;
                  ax = 32'h0;
                  bx = ~b;
                  ci = 1'b1;
               end
               `CAD_ALU_CMP: begin
                  use_add = 1'b1;
                  bx = ~b;
                  ci = 1'b1;
                  wr = 1'b0;
               end
               `CAD_ALU_CMN: begin
                  use_add = 1'b1;
                  wr = 1'b0;
               end
               default: begin
                  res = b * a;
                  // multiplier early termination on the destination value
                  if (a[31:8] == 24'h0 || a[31:8] == 24'hffffff)
                     extra = `CAD_XTRA_MUL1;
                  else if (a[31:16] == 16'h0 || a[31:16] == 16'hffff)
                     extra = `CAD_XTRA_MUL2;
                  else if (a[31:24] == 8'h0 || a[31:24] == 8'hff)
                     extra = `CAD_XTRA_MUL3;
                  else
                     extra = `CAD_XTRA_MUL4;
               end
            endcase
         end
      endcase
      s = cad_add(ax, bx, ci);
      if (use_add) begin
         res = s[31:0];
         nc = s[32];
         nv = s[33];
      end
   end

   // sequencer: take, read operands, compute, idle cycles, commit
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         state <= ST_IDLE;
         ir <= 16'h0;
         fmt <= `CAD_FMT_SHIFT;
         dest <= 3'h0;
         cnt <= 3'h0;
         res_q <= 32'h0;
         wr_q <= 1'b0;
         flags_q <= `CAD_FLAGS_RST;
         INSTR_READY <= 1'b0;
         INSTR_ILLEGAL <= 1'b0;
         RD_ADDR_A <= 3'h0;
         RD_ADDR_B <= 3'h0;
         WR_EN <= 1'b0;
         WR_ADDR <= 3'h0;
         WR_DATA <= 32'h0;
         DONE <= 1'b0;
         {FLAG_N, FLAG_Z, FLAG_C, FLAG_V} <= `CAD_FLAGS_RST;
      end else begin
         WR_EN <= 1'b0;
         DONE <= 1'b0;
         INSTR_ILLEGAL <= 1'b0;
         case (state)
            ST_IDLE: begin
               INSTR_READY <= 1'b1;
               if (take && !in_legal) begin
                  INSTR_ILLEGAL <= 1'b1;
               end else if (take) begin
                  ir <= INSTR;
                  INSTR_READY <= 1'b0;
                  state <= ST_EXEC;
                  // register fields are three bits wide, low group only
                  if (in_f3) begin
                     fmt <= `CAD_FMT_IMM8;
                     dest <= INSTR[`CAD_F3_DST_HI:`CAD_F3_DST_LO];
                     RD_ADDR_A <= INSTR[`CAD_F3_DST_HI:`CAD_F3_DST_LO];
                  end else if (in_f4) begin
                     fmt <= `CAD_FMT_ALU;
                     dest <= INSTR[`CAD_DST_HI:`CAD_DST_LO];
                     RD_ADDR_A <= INSTR[`CAD_DST_HI:`CAD_DST_LO];
                     RD_ADDR_B <= INSTR[`CAD_SRC_HI:`CAD_SRC_LO];
                  end else begin
                     fmt <= (in_op2 == `CAD_OP2_ADDSUB) ? `CAD_FMT_ADDSUB : `CAD_FMT_SHIFT;
                     dest <= INSTR[`CAD_DST_HI:`CAD_DST_LO];
                     RD_ADDR_A <= INSTR[`CAD_SRC_HI:`CAD_SRC_LO];
                     RD_ADDR_B <= INSTR[`CAD_SEC_HI:`CAD_SEC_LO];
                  end
               end
            end
            ST_EXEC: begin
               res_q <= res;
               wr_q <= wr;
               flags_q <= {res[31], res == 32'h0, nc, nv};
               if (extra == 3'h0) begin
                  WR_EN <= wr;
                  WR_ADDR <= dest;
                  WR_DATA <= res;
                  DONE <= 1'b1;
                  {FLAG_N, FLAG_Z, FLAG_C, FLAG_V} <= {res[31], res == 32'h0, nc, nv};
                  INSTR_READY <= 1'b1;
                  state <= ST_IDLE;
               end else begin
                  cnt <= extra;
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               cnt <= cnt - 3'h1;
               if (cnt == 3'h1) begin
                  WR_EN <= wr_q;
                  WR_ADDR <= dest;
                  WR_DATA <= res_q;
                  DONE <= 1'b1;
                  {FLAG_N, FLAG_Z, FLAG_C, FLAG_V} <= flags_q;
                  INSTR_READY <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

// >>> verif/cad_exec_chk.sv
`timescale 1ns/1ps
module cad_exec_chk (
   input wire CLK_SYS,
   input wire RESET,
   input wire INSTR_VALID,
   input wire [15:0] INSTR,
   input wire INSTR_READY,
   input wire INSTR_ILLEGAL,
   input wire WR_EN,
   input wire [2:0] WR_ADDR,
   input wire DONE,
   input wire FLAG_N,
   input wire FLAG_Z,
   input wire FLAG_C,
   input wire FLAG_V
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   // decode of the word offered this cycle
   wire take = INSTR_VALID && INSTR_READY;
   wire alu = INSTR[15:10] == 6'h10;
   wire i8 = INSTR[15:13] == 3'h1;
   wire legal = alu || i8 || INSTR[15:13] == 3'h0;
   wire rsh = alu && (INSTR[9:6] inside {4'h2, 4'h3, 4'h4, 4'h7});
   wire mul = alu && INSTR[9:6] == 4'hd;
   wire nowr = (i8 && INSTR[12:11] == 2'h1) || (alu && INSTR[9:8] == 2'h2 && INSTR[7:6] != 2'h1);
   a_plain_lat: assert property (take && legal && !rsh && !mul |-> ##2 DONE)
      else $error("done late for a one-cycle instruction");
   a_rshift_lat: assert property (take && rsh |-> ##1 !DONE ##1 !DONE ##1 DONE)
      else $error("register shift not three cycles");
   a_mul_lat: assert property (take && mul |-> ##[3:6] DONE)
      else $error("multiply latency out of range");
   a_busy_refuse: assert property (take && legal |=> !INSTR_READY && !INSTR_ILLEGAL)
      else $error("ready while busy");
   a_ill_drop: assert property (take && !legal |=> INSTR_ILLEGAL && INSTR_READY && !DONE && !WR_EN)
      else $error("foreign word not dropped");
   a_no_write: assert property (take && nowr |-> ##2 DONE && !WR_EN)
      else $error("compare or test wrote a register");
   a_imm_dest: assert property (take && i8 && INSTR[12:11] != 2'h1 |-> ##2 WR_EN && WR_ADDR == $past(INSTR[10:8], 2))
      else $error("byte immediate wrong destination");
   a_flag_hold: assert property ($changed({FLAG_N, FLAG_Z, FLAG_C, FLAG_V}) |-> DONE)
      else $error("flags moved without completion");
   a_ready_done: assert property (DONE |-> INSTR_READY)
      else $error("not ready at completion");
   a_mov_zero: assert property (take && INSTR[15:11] == 5'h04 && INSTR[7:0] == 8'h00 |-> ##2 FLAG_Z && !FLAG_N)
      else $error("zero load flags wrong");
endmodule

bind cad_exec cad_exec_chk cad_exec_chk_i (.CLK_SYS(CLK_SYS), .RESET(RESET), .INSTR_VALID(INSTR_VALID),
   .INSTR(INSTR), .INSTR_READY(INSTR_READY), .INSTR_ILLEGAL(INSTR_ILLEGAL), .WR_EN(WR_EN),
   .WR_ADDR(WR_ADDR), .DONE(DONE), .FLAG_N(FLAG_N), .FLAG_Z(FLAG_Z), .FLAG_C(FLAG_C), .FLAG_V(FLAG_V));

// >>> verif/cad_lrf.sv
`timescale 1ns/1ps
module cad_lrf (
   input wire clk,
   input wire [2:0] rd_addr_a,
   input wire [2:0] rd_addr_b,
   output wire [31:0] rd_data_a,
   output wire [31:0] rd_data_b,
   input wire wr_en,
   input wire [2:0] wr_addr,
   input wire [31:0] wr_data
);
   // only the eight low registers exist here
   logic [31:0] mem [0:7];
   // combinational reads
   assign rd_data_a = mem[rd_addr_a];
   assign rd_data_b = mem[rd_addr_b];
   // write lands on the pulse edge, so the next read sees it
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end
endmodule

// >>> verif/test_cad_exec.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module test_cad_exec;
   logic CLK_SYS = 1'b0;
   logic RESET = 1'b1;
   logic INSTR_VALID = 1'b0;
   logic [15:0] INSTR = 16'h0000;
   wire [31:0] RD_DATA_A, RD_DATA_B, WR_DATA;
   wire [2:0] RD_ADDR_A, RD_ADDR_B, WR_ADDR;
   wire INSTR_READY, INSTR_ILLEGAL, WR_EN, DONE, FLAG_N, FLAG_Z, FLAG_C, FLAG_V;
   int n_errors = 0;
   int comparisons = 0;
   logic [31:0] regs [0:7];
   logic [3:0] fl = 4'h0;
   logic [40:0] notes [$];
   logic [40:0] got, exp_n;
   logic [31:0] spec [0:7] = '{32'h0, 32'h7fffffff, 32'h80000000, 32'hffffffff, 32'h20, 32'h21, 32'h1f, 32'h1};
   logic [15:0] ill [0:3] = '{16'h4400, 16'h4700, 16'h6000, 16'hffff};

   cad_exec cad_exec_i (.CLK_SYS(CLK_SYS), .RESET(RESET), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
      .RD_DATA_A(RD_DATA_A), .RD_DATA_B(RD_DATA_B), .INSTR_READY(INSTR_READY), .INSTR_ILLEGAL(INSTR_ILLEGAL),
      .RD_ADDR_A(RD_ADDR_A), .RD_ADDR_B(RD_ADDR_B), .WR_EN(WR_EN), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
      .DONE(DONE), .FLAG_N(FLAG_N), .FLAG_Z(FLAG_Z), .FLAG_C(FLAG_C), .FLAG_V(FLAG_V));
   cad_lrf cad_lrf_i (.clk(CLK_SYS), .rd_addr_a(RD_ADDR_A), .rd_addr_b(RD_ADDR_B), .rd_data_a(RD_DATA_A),
      .rd_data_b(RD_DATA_B), .wr_en(WR_EN), .wr_addr(WR_ADDR), .wr_data(WR_DATA));

   // adder giving {overflow, carry, sum}
   function automatic logic [33:0] add(input logic [31:0] x, input logic [31:0] y, input logic ci);
      logic [32:0] s;
      s = {1'b0, x} + {1'b0, y} + {32'h0, ci};
      return {(x[31] == y[31]) && (s[31] != x[31]), s};
   endfunction

   // shifter giving {carry, result}; a zero amount keeps the carry
   function automatic logic [32:0] shf(input logic [1:0] k, input logic [31:0] x, input logic [7:0] n, input logic ci);
      logic [32:0] t;
      if (n == 8'h00) return {ci, x};
      case (k)
         2'h0: t = {1'b0, x} << n;
         2'h1: t = {x, 1'b0} >> n;
         2'h2: t = $signed({x, 1'b0}) >>> n;
         default: t = {(x >> n[4:0]) | (x << (6'h20 - n[4:0])), 1'b0};
      endcase
      if (k == 2'h3) t[0] = t[32];
      return (k == 2'h0) ? t : {t[0], t[32:1]};
   endfunction

   // work out the result of one word and note it
   task automatic predict(input logic [15:0] w);
      logic [31:0] a, b, r;
      logic [3:0] op;
      logic [2:0] d;
      logic c, v, wr;
      d = w[2:0];
      a = regs[w[5:3]];
      b = regs[w[8:6]];
      op = w[9:6];
      {c, v} = fl[1:0];
      wr = 1'b1;
      r = 32'h0;
      if (w[15:11] == 5'h03) begin
         if (w[10]) b = {29'h0, w[8:6]};
         {v, c, r} = w[9] ? add(a, ~b, 1'b1) : add(a, b, 1'b0);
      end else if (w[15:13] == 3'h0) begin
         {c, r} = shf(w[12:11], a, (w[12:11] != 2'h0 && w[10:6] == 5'h0) ? 8'h20 : {3'h0, w[10:6]}, c);
      end else if (w[15:13] == 3'h1) begin
         d = w[10:8];
         b = {24'h0, w[7:0]};
         wr = w[12:11] != 2'h1;
         if (w[12:11] == 2'h0) r = b;
         else {v, c, r} = (w[12:11] == 2'h2) ? add(regs[d], b, 1'b0) : add(regs[d], ~b, 1'b1);
      end else if (w[15:10] == 6'h10) begin
         a = regs[d];
         b = regs[w[5:3]];
         wr = !(op inside {4'h8, 4'ha, 4'hb});
         case (op)
            4'h0, 4'h8: r = a & b;
            4'h1: r = a ^ b;
            4'h2, 4'h3, 4'h4, 4'h7: {c, r} = shf(op == 4'h7 ? 2'h3 : op[1:0] + 2'h2, a, b[7:0], c);
            4'h5: {v, c, r} = add(a, b, c);
            4'h6, 4'ha: {v, c, r} = add(a, ~b, op[3] | c);
            4'h9: {v, c, r} = add(32'h0, ~b, 1'b1);
            4'hb: {v, c, r} = add(a, b, 1'b0);
            4'hc: r = a | b;
            4'hd: r = a * b;
            4'he: r = a & ~b;
            default: r = ~b;
         endcase
      end else begin
         notes.push_back({1'b1, 1'b0, 35'h0, fl});
         return;
      end
      fl = {r[31], r == 32'h0, c, v};
      if (wr) regs[d] = r;
      notes.push_back({1'b0, wr, wr ? d : 3'h0, wr ? r : 32'h0, fl});
   endtask

   // offer a word and hold it until the edge that takes it
   task automatic issue(input logic [15:0] w);
      int k;
      predict(w);
      INSTR_VALID <= 1'b1;
      INSTR <= w;
      k = 0;
      do begin
         @(posedge CLK_SYS);
         k++;
      end while (INSTR_READY !== 1'b1 && k < 20);
      if (k >= 20) n_errors++;
   endtask

   // release the port and let outstanding results arrive, then reload registers
   task automatic settle(input int rot);
      int k;
      INSTR_VALID <= 1'b0;
      k = 0;
      while (notes.size() != 0 && k < 20) begin
         @(posedge CLK_SYS);
         k++;
      end
      @(posedge CLK_SYS);
      // results that never arrived count as a mismatch
      if (notes.size() != 0) n_errors++;
      for (int i = 0; i < 8; i++) begin
         regs[i] = (rot < 0) ? $urandom : spec[(i + rot) % 8];
         cad_lrf_i.mem[i] = regs[i];
      end
   endtask

   // random word of format f with op code op
   function automatic logic [15:0] mk(input int f, input int op, input int rep);
      logic [15:0] w;
      w = 16'($urandom);
      if (rep == 0) w[10:6] = 5'h00;
      if (rep == 0 && f == 2) w[7:0] = 8'h00;
      if (rep == 1) w[10:6] = 5'h1f;
      w[15:11] = (f == 1) ? 5'h03 : {2'h0, f == 2, 2'(op)};
      if (f == 1) w[10:9] = 2'(op);
      if (f == 3) w[15:6] = {6'h10, 4'(op)};
      return w;
   endfunction

   task automatic tally_and_finish();
      $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // result watcher takes the oldest note on each completion
   always @(posedge CLK_SYS) begin
      if (!RESET && (DONE === 1'b1 || INSTR_ILLEGAL === 1'b1)) begin
         got = {INSTR_ILLEGAL, WR_EN, WR_EN ? WR_ADDR : 3'h0, WR_EN ? WR_DATA : 32'h0, FLAG_N, FLAG_Z, FLAG_C, FLAG_V};
         exp_n = (notes.size() != 0) ? notes.pop_front() : '1;
         `CHK(got, exp_n)
      end
   end

   initial begin
      forever #2.5 CLK_SYS = ~CLK_SYS;
   end

   initial begin
      #100000;
      n_errors++;
      tally_and_finish();
   end

   // main sequence
   initial begin
      void'($urandom(32'ha57b5a36));
      repeat (6) @(posedge CLK_SYS);
      RESET <= 1'b0;
      `CHK(({FLAG_N, FLAG_Z, FLAG_C, FLAG_V, INSTR_READY, DONE}), 6'h00)
      repeat (2) @(posedge CLK_SYS);
      for (int f = 0; f < 4; f++) begin
         for (int rep = 0; rep < 8; rep++) begin
            settle(rep);
            for (int op = 0; op < ((f == 0) ? 3 : (f == 3) ? 16 : 4); op++) issue(mk(f, op, rep));
         end
         $display("test format %0d done", f);
      end
      settle(-1);
      for (int i = 0; i < 4; i++) issue(ill[i]);
      issue(mk(3, 13, 2));
      $display("test foreign words done");
      for (int i = 0; i < 150; i++) begin
         if (i % 30 == 0) settle(-1);
         issue(mk(i % 4, $urandom % ((i % 4 == 0) ? 3 : (i % 4 == 3) ? 16 : 4), 2));
      end
      settle(0);
      $display("test random mix done");
      tally_and_finish();
   end
endmodule
